// File: core/pis_map.svh
`ifndef PIS_MAP_SVH
`define PIS_MAP_SVH

// Register byte offsets
`define PIS_REG_CTRL 8'h00
`define PIS_REG_SCALE_LO 8'h04
`define PIS_REG_SCALE_HI 8'h08
`define PIS_REG_RANGE_LO 8'h0c
`define PIS_REG_RANGE_HI 8'h10
`define PIS_REG_OFFSET 8'h14
`define PIS_REG_ERR_LOW 8'h18
`define PIS_REG_FILTER 8'h1c
`define PIS_REG_CLEAR 8'h20
`define PIS_REG_STATUS 8'h24
`define PIS_REG_VALUE 8'h28
`define PIS_REG_NAME0 8'h30
`define PIS_NAME_WORDS 5

// Control fields
`define PIS_CTRL_SENSOR_LSB 0
`define PIS_CTRL_UNITS_LSB 2
`define PIS_CTRL_PREC_LSB 4
`define PIS_CTRL_ERR_EN_BIT 6
`define PIS_CTRL_LATCH_BIT 7
`define PIS_CTRL_CELSIUS_BIT 8
`define PIS_CTRL_WIDTH 9
`define PIS_CTRL_RESET 9'h000

// Status fields
`define PIS_STAT_ERR_BIT 0
`define PIS_STAT_NSRC_BIT 1
`define PIS_STAT_BUSY_BIT 2

// Value limits, milli-units; filter limit in tenths of a second
`define PIS_ELEC_MIN (-32'sd100000)
`define PIS_ELEC_MAX 32'sd1000000
`define PIS_PROC_MIN (-32'sd99999000)
`define PIS_PROC_MAX 32'sd99999000
`define PIS_CELS_MIN (-32'sd55555000)
`define PIS_CELS_MAX 32'sd55555000
`define PIS_PWR_MIN 32'sd0
`define PIS_PWR_MAX 32'sd100000
`define PIS_FILT_MAX 10'h258

// Scaling reset points: 4 mA..20 mA onto 0..10
`define PIS_SCALE_LO_RESET 32'sd4000
`define PIS_SCALE_HI_RESET 32'sd20000
`define PIS_RANGE_LO_RESET 32'sd0
`define PIS_RANGE_HI_RESET 32'sd10000

// Timing
`define PIS_CLK_NS 40
`define PIS_TICK_NS 1000000
`define PIS_TICK_CYCLES (`PIS_TICK_NS / `PIS_CLK_NS)
`define PIS_FILT_MS_PER_STEP 100
`define PIS_DIV_STEPS 64

`endif

// File: core/pis_pkg.sv
package pis_pkg;
	typedef enum logic [1:0] {
		PIS_SENSOR_OFF = 2'h0,
		PIS_SENSOR_MV = 2'h1,
		PIS_SENSOR_V = 2'h2,
		PIS_SENSOR_MA = 2'h3
	} pis_sensor_e;

	typedef enum logic [1:0] {
		PIS_UNIT_POWER = 2'h0,
		PIS_UNIT_PROCESS = 2'h1,
		PIS_UNIT_RH = 2'h2,
		PIS_UNIT_TEMP = 2'h3
	} pis_units_e;

	typedef enum logic [1:0] {
		PIS_PREC_WHOLE = 2'h0,
		PIS_PREC_TENTHS = 2'h1,
		PIS_PREC_HUNDREDTHS = 2'h2,
		PIS_PREC_THOUSANDTHS = 2'h3
	} pis_prec_e;

	// Gray order along idle, divide, done
	typedef enum logic [1:0] {
		PIS_ST_IDLE = 2'h0,
		PIS_ST_DIV = 2'h1,
		PIS_ST_DONE = 2'h3
	} pis_state_e;

	typedef logic signed [31:0] pis_fix_t;
endpackage

// File: core/pis_scaler.sv
`timescale 1ns/10ps
`default_nettype none
`include "pis_map.svh"
//
// Contract
// - Output follows line through two points
// - Midpoint input gives interpolated process value
// - Electrical points limited to -100.0..1000.0
// - Process points limited to +-99999.000
// - Signed calibration offset added to value
// - Filter 0.0..60.0 s, longer smoother
// - Low check raises error below minimum
// - Unlatched error drops when signal normal
// - Latched error needs normal plus clear
// - Units power, process, humidity, temperature
// - Precision whole to thousandths selectable
// - Off reports unsourced, loop held 0%
// - Output undefined while input off
// - Millivolt, volt and milliamp types treated alike; only off differs
// - Twenty character identifier stored
module pis_scaler import pis_pkg::*; #(
	parameter int TICK_CYCLES = `PIS_TICK_CYCLES
) (
	input wire logic clock,
	input wire logic reset,
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	output logic [31:0] reg_rdata,
	input wire logic sample_valid,
	input wire logic signed [31:0] sample_data,
	output logic sample_ready,
	output logic signed [31:0] process_value,
	output logic process_valid,
	output logic input_error,
	output logic not_sourced,
	output logic loop_hold_zero,
	output logic [1:0] output_units,
	output logic [1:0] display_precision
);

	// Saturate a fixed-point value into a window
	function automatic pis_fix_t sat(input logic signed [47:0] v,
		input pis_fix_t lo, input pis_fix_t hi);
		if (v < 48'(lo))
			sat = lo;
		else if (v > 48'(hi))
			sat = hi;
		else
			sat = v[31:0];
	endfunction

	// Shift that makes 2^k ms near the filter time
	function automatic logic [3:0] filt_shift(input logic [9:0] tenths);
		logic [15:0] ms;
		ms = 16'(tenths) * 16'(`PIS_FILT_MS_PER_STEP);
		filt_shift = 4'h0;
		for (int i = 1; i < 16; i++) begin
			if (ms[i])
				filt_shift = 4'(i);
		end
	endfunction

	logic [`PIS_CTRL_WIDTH-1:0] ctrl;
	pis_fix_t scale_lo, scale_hi, range_lo, range_hi;
	pis_fix_t cal_offset, err_low;
	logic [9:0] filt_time;
	logic [31:0] name_word [`PIS_NAME_WORDS];
	logic clear_req;
	pis_sensor_e sensor;
	pis_units_e units;
	logic celsius;
	pis_fix_t proc_min, proc_max;
	logic signed [47:0] wide_wdata;

	assign sensor = pis_sensor_e'(ctrl[`PIS_CTRL_SENSOR_LSB +: 2]);
	assign units = pis_units_e'(ctrl[`PIS_CTRL_UNITS_LSB +: 2]);
	assign celsius = ctrl[`PIS_CTRL_CELSIUS_BIT];
	assign wide_wdata = 48'(signed'(reg_wdata));

	// Narrower limits apply to temperature on the Celsius scale
	always_comb begin
		if (units == PIS_UNIT_TEMP && celsius) begin
			proc_min = `PIS_CELS_MIN;
			proc_max = `PIS_CELS_MAX;
		end else begin
			proc_min = `PIS_PROC_MIN;
			proc_max = `PIS_PROC_MAX;
		end
	end

	// Configuration writes, clamped into their legal spans
	always_ff @(posedge clock) begin
		if (reset) begin
			ctrl <= `PIS_CTRL_RESET;
			scale_lo <= `PIS_SCALE_LO_RESET;
			scale_hi <= `PIS_SCALE_HI_RESET;
			range_lo <= `PIS_RANGE_LO_RESET;
			range_hi <= `PIS_RANGE_HI_RESET;
			cal_offset <= 32'sh0;
			err_low <= 32'sh0;
			filt_time <= 10'h0;
		end else if (reg_write) begin
			unique case (reg_addr)
				`PIS_REG_CTRL: ctrl <= reg_wdata[`PIS_CTRL_WIDTH-1:0];
				`PIS_REG_SCALE_LO: scale_lo <= sat(wide_wdata,
					`PIS_ELEC_MIN, `PIS_ELEC_MAX);
				`PIS_REG_SCALE_HI: scale_hi <= sat(wide_wdata,
					`PIS_ELEC_MIN, `PIS_ELEC_MAX);
				`PIS_REG_RANGE_LO: range_lo <= sat(wide_wdata,
					proc_min, proc_max);
				`PIS_REG_RANGE_HI: range_hi <= sat(wide_wdata,
					proc_min, proc_max);
				`PIS_REG_OFFSET: cal_offset <= sat(wide_wdata,
					proc_min, proc_max);
				`PIS_REG_ERR_LOW: err_low <= sat(wide_wdata,
					`PIS_ELEC_MIN, `PIS_ELEC_MAX);
				`PIS_REG_FILTER: filt_time <= (reg_wdata[31:10] != 22'h0 ||
					reg_wdata[9:0] > `PIS_FILT_MAX) ?
					`PIS_FILT_MAX : reg_wdata[9:0];
				default: ;
			endcase
		end
	end

	// Identifier storage, four characters a word
	generate
		for (genvar g = 0; g < `PIS_NAME_WORDS; g++) begin : g_name
			always_ff @(posedge clock) begin
				if (reset)
					name_word[g] <= 32'h0;
				else if (reg_write && reg_addr == 8'(`PIS_REG_NAME0 + 4 * g))
					name_word[g] <= reg_wdata;
			end
		end
	endgenerate

	// Clear is a write-only strobe, no storage
	assign clear_req = reg_write && reg_addr == `PIS_REG_CLEAR &&
		reg_wdata[0];

	// Sample capture and long division for the scaling line
	pis_state_e state;
	logic [5:0] div_count;
	logic [63:0] div_quo;
	logic [32:0] div_rem;
	logic [31:0] div_den;
	logic div_neg;
	pis_fix_t elec_in, scaled;
	logic signed [63:0] num_full;
	logic signed [32:0] den_full;
	logic [32:0] rem_shift;
	logic [31:0] quo_mag;

	assign sample_ready = (state == PIS_ST_IDLE);
	assign num_full = 64'(sample_data - scale_lo) *
		64'(range_hi - range_lo);
	assign den_full = 33'(scale_hi) - 33'(scale_lo);
	assign rem_shift = {div_rem[31:0], div_quo[63]};
	// A steep line can outgrow 31 bits; clip rather than wrap
	assign quo_mag = (div_quo[63:31] != 33'h0) ? 32'h7fffffff :
		div_quo[31:0];

	always_ff @(posedge clock) begin
		if (reset) begin
			state <= PIS_ST_IDLE;
			div_count <= 6'h0;
			div_quo <= 64'h0;
			div_rem <= 33'h0;
			div_den <= 32'h0;
			div_neg <= 1'b0;
			elec_in <= 32'sh0;
			scaled <= 32'sh0;
		end else begin
			unique case (state)
				PIS_ST_IDLE: begin
					if (sample_valid) begin
						elec_in <= sample_data;
						div_quo <= num_full[63] ? 64'(-num_full) :
							64'(num_full);
						div_den <= den_full[32] ? 32'(-den_full) :
							32'(den_full);
						div_neg <= num_full[63] ^ den_full[32];
						div_rem <= 33'h0;
						div_count <= 6'h0;
						state <= PIS_ST_DIV;
					end
				end
				PIS_ST_DIV: begin
					if (rem_shift >= {1'b0, div_den}) begin
						div_rem <= rem_shift - {1'b0, div_den};
						div_quo <= {div_quo[62:0], 1'b1};
					end else begin
						div_rem <= rem_shift;
						div_quo <= {div_quo[62:0], 1'b0};
					end
					div_count <= div_count + 6'h1;
					if (div_count == 6'(`PIS_DIV_STEPS - 1))
						state <= PIS_ST_DONE;
				end
				PIS_ST_DONE: begin
					// Equal points give no slope; hold at the low value
					if (div_den == 32'h0)
						scaled <= range_lo;
					else
						scaled <= sat(48'(range_lo) + (div_neg ?
							-48'(quo_mag) : 48'(quo_mag)),
							`PIS_PROC_MIN, `PIS_PROC_MAX);
					state <= PIS_ST_IDLE;
				end
			endcase
		end
	end

	// Millisecond time base for the filter
	logic [15:0] tick_count;
	logic tick;
	assign tick = (tick_count == 16'(TICK_CYCLES - 1));
	always_ff @(posedge clock) begin
		if (reset || tick)
			tick_count <= 16'h0;
		else
			tick_count <= tick_count + 16'h1;
	end

	// First-order smoothing; 16 fraction bits stop small steps stalling
	logic signed [47:0] filt_acc;
	logic signed [47:0] filt_diff;
	logic [3:0] k;
	logic [4:0] shift;
	assign k = filt_shift(filt_time);
	// Five bits so the longest setting does not wrap to no filtering
	assign shift = {1'b0, k} + 5'h1;
	assign filt_diff = {scaled, 16'h0} - filt_acc;
	always_ff @(posedge clock) begin
		if (reset)
			filt_acc <= 48'sh0;
		else if (filt_time == 10'h0)
			filt_acc <= {scaled, 16'h0};
		else if (tick)
			filt_acc <= filt_acc + (filt_diff >>> shift);
	end

	// Offset, then power units clipped to 0..100 %
	logic signed [47:0] with_offset;
	pis_fix_t next_value;
	// Part-select drops the sign, so restore it before widening
	assign with_offset = 48'(signed'(filt_acc[47:16])) +
		48'(cal_offset);
	always_comb begin
		if (units == PIS_UNIT_POWER)
			next_value = sat(with_offset, `PIS_PWR_MIN,
				`PIS_PWR_MAX);
		else
			next_value = sat(with_offset, `PIS_PROC_MIN,
				`PIS_PROC_MAX);
	end

	// Value publishes each tick; off drives zero, not to be trusted
	always_ff @(posedge clock) begin
		if (reset) begin
			process_value <= 32'sh0;
			process_valid <= 1'b0;
		end else begin
			process_valid <= tick && sensor != PIS_SENSOR_OFF;
			if (sensor == PIS_SENSOR_OFF)
				process_value <= 32'sh0;
			else if (tick)
				process_value <= next_value;
		end
	end

	// Low-signal check on the raw electrical level
	logic low_fault;
	assign low_fault = ctrl[`PIS_CTRL_ERR_EN_BIT] &&
		sensor != PIS_SENSOR_OFF && elec_in < err_low;
	always_ff @(posedge clock) begin
		if (reset)
			input_error <= 1'b0;
		else if (low_fault)
			input_error <= 1'b1;
		else if (!ctrl[`PIS_CTRL_LATCH_BIT])
			input_error <= 1'b0;
		else if (clear_req)
			input_error <= 1'b0;
	end

	// Unsourced flag and loop hold follow the off type
	always_ff @(posedge clock) begin
		if (reset) begin
			not_sourced <= 1'b1;
			loop_hold_zero <= 1'b1;
		end else begin
			not_sourced <= (sensor == PIS_SENSOR_OFF);
			loop_hold_zero <= (sensor == PIS_SENSOR_OFF);
		end
	end

	assign output_units = units;
	assign display_precision = ctrl[`PIS_CTRL_PREC_LSB +: 2];

	// Read data one cycle after the strobe; unmapped reads zero
	logic [31:0] next_rdata;
	always_comb begin
		next_rdata = 32'h0;
		unique case (reg_addr)
			`PIS_REG_CTRL: next_rdata = 32'(ctrl);
			`PIS_REG_SCALE_LO: next_rdata = scale_lo;
			`PIS_REG_SCALE_HI: next_rdata = scale_hi;
			`PIS_REG_RANGE_LO: next_rdata = range_lo;
			`PIS_REG_RANGE_HI: next_rdata = range_hi;
			`PIS_REG_OFFSET: next_rdata = cal_offset;
			`PIS_REG_ERR_LOW: next_rdata = err_low;
			`PIS_REG_FILTER: next_rdata = 32'(filt_time);
			`PIS_REG_STATUS: begin
				next_rdata[`PIS_STAT_ERR_BIT] = input_error;
				next_rdata[`PIS_STAT_NSRC_BIT] = not_sourced;
				next_rdata[`PIS_STAT_BUSY_BIT] = !sample_ready;
			end
			`PIS_REG_VALUE: next_rdata = process_value;
			default: begin
				for (int i = 0; i < `PIS_NAME_WORDS; i++) begin
					if (reg_addr == 8'(`PIS_REG_NAME0 + 4 * i))
						next_rdata = name_word[i];
				end
			end
		endcase
	end

	always_ff @(posedge clock) begin
		if (reset)
			reg_rdata <= 32'h0;
		else if (reg_read)
			reg_rdata <= next_rdata;
		else
			reg_rdata <= 32'h0;
	end

endmodule
`default_nettype wire

// File: sim/pis_adc_model.sv
`timescale 1ns/10ps
`default_nettype none
// Analog front end: offers the level, held until the scaler takes it
module pis_adc_model (
	input wire logic clock,
	input wire logic reset,
	input wire logic sample_ready,
	input wire logic signed [31:0] level,
	output logic sample_valid,
	output logic signed [31:0] sample_data
);
	// New level only after a take, so an offer never changes under wait
	always_ff @(posedge clock) begin
		if (reset) begin
			sample_valid <= 1'b0;
			sample_data <= 32'h0;
		end else if (!sample_valid || sample_ready) begin
			sample_valid <= 1'b1;
			sample_data <= level;
		end
	end
endmodule
`default_nettype wire

// File: sim/pis_scaler_chk.sv
`timescale 1ns/10ps
`default_nettype none
`include "pis_map.svh"
module pis_scaler_chk #(
	parameter int TICK_CYCLES = 20
) (
	input wire logic clock,
	input wire logic reset,
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	input wire logic [31:0] reg_rdata,
	input wire logic sample_valid,
	input wire logic sample_ready,
	input wire logic signed [31:0] process_value,
	input wire logic process_valid,
	input wire logic input_error,
	input wire logic not_sourced,
	input wire logic loop_hold_zero,
	input wire logic [1:0] output_units,
	input wire logic [1:0] display_precision
);
	default clocking @(posedge clock); endclocking
	default disable iff (reset);
	// Capture then a busy spell of the divider
	sequence s_take;
		sample_valid && sample_ready;
	endsequence
	sequence s_busy;
		!sample_ready [*8];
	endsequence
	a_hold_tracks: assert property (loop_hold_zero == not_sourced)
		else $error("loop hold differs from unsourced flag");
	a_rdata_idle: assert property (!$past(reg_read) |-> reg_rdata == 32'h0)
		else $error("read data outside its cycle");
	a_status_mirror: assert property ($past(reg_read &&
		reg_addr == `PIS_REG_STATUS) |-> reg_rdata[1:0] ==
		{$past(not_sourced), $past(input_error)})
		else $error("status word wrong");
	a_value_mirror: assert property ($past(reg_read &&
		reg_addr == `PIS_REG_VALUE) |-> reg_rdata == $past(process_value))
		else $error("value word wrong");
	a_ctrl_fields: assert property ($past(reg_write &&
		reg_addr == `PIS_REG_CTRL) |-> output_units == $past(reg_wdata[3:2])
		&& display_precision == $past(reg_wdata[5:4]))
		else $error("units or precision not taken");
	a_off_zero: assert property (not_sourced [*3] |->
		process_value == 32'sd0) else $error("value not zero while off");
	a_valid_pulse: assert property (process_valid |=>
		!process_valid [*8]) else $error("valid pulse too long");
	a_power_clip: assert property (process_valid && output_units == 2'h0
		&& $stable(output_units) |-> process_value >= 32'sd0 &&
		process_value <= 32'sd100000) else $error("power out of range");
	a_ready_cycle: assert property (s_take |=> s_busy
		##57 !sample_ready ##1 sample_ready) else $error("divide span wrong");
	a_valid_off: assert property (not_sourced |-> !process_valid)
		else $error("value strobe while off");
endmodule
bind pis_scaler pis_scaler_chk #(.TICK_CYCLES(TICK_CYCLES)) u_chk (
	.clock(clock), .reset(reset), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
	.reg_rdata(reg_rdata), .sample_valid(sample_valid),
	.sample_ready(sample_ready), .process_value(process_value),
	.process_valid(process_valid), .input_error(input_error),
	.not_sourced(not_sourced), .loop_hold_zero(loop_hold_zero),
	.output_units(output_units), .display_precision(display_precision));
`default_nettype wire

// File: sim/test_process_input_scaler.sv
`timescale 1ns/10ps
`default_nettype none
`include "pis_map.svh"
module test_process_input_scaler;
	logic clock = 1'b0, reset = 1'b1, reg_write = 1'b0, reg_read = 1'b0;
	logic [7:0] reg_addr = 8'h0;
	logic [31:0] reg_wdata = 32'h0, reg_rdata, rv;
	logic [31:0] nm [5];
	logic sample_valid, sample_ready, process_valid, input_error;
	logic not_sourced, loop_hold_zero;
	logic signed [31:0] sample_data, process_value, level = 32'sd8000;
	logic [1:0] output_units, display_precision;
	int errors = 0, total_checks = 0, off, lv;
	// Clock, 40 ns period
	always #20 clock = ~clock;
	// Short tick keeps the run brief
	pis_scaler #(.TICK_CYCLES(20)) dut (.clock(clock), .reset(reset),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
		.reg_read(reg_read), .reg_rdata(reg_rdata),
		.sample_valid(sample_valid), .sample_data(sample_data),
		.sample_ready(sample_ready), .process_value(process_value),
		.process_valid(process_valid), .input_error(input_error),
		.not_sourced(not_sourced), .loop_hold_zero(loop_hold_zero),
		.output_units(output_units), .display_precision(display_precision));
	pis_adc_model adc (.clock(clock), .reset(reset),
		.sample_ready(sample_ready), .level(level),
		.sample_valid(sample_valid), .sample_data(sample_data));
	task final_report;
		$display("checks %0d errors %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task check_word(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			errors++;
			$display("ERROR %0t word %h want %h", $time, got, exp);
		end
	endtask
	task check_flag(input logic got, input logic exp);
		total_checks++;
		if (got !== exp) begin
			errors++;
			$display("ERROR %0t flag %b want %b", $time, got, exp);
		end
	endtask
	// Bus cycles, strobes one cycle wide
	task wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clock);
		reg_addr <= a;
		reg_wdata <= d;
		reg_write <= 1'b1;
		@(posedge clock);
		reg_write <= 1'b0;
	endtask
	task rd(input logic [7:0] a);
		@(posedge clock);
		reg_addr <= a;
		reg_read <= 1'b1;
		@(posedge clock);
		reg_read <= 1'b0;
		#1 rv = reg_rdata;
	endtask
	// Room for three divides and a tick: one stale offer may go first
	task put(input int l);
		level <= l;
		repeat (300) @(posedge clock);
	endtask
	// Line through 4000,0 and 20000,10000, truncating toward zero
	function automatic logic [31:0] expect_val(int x, int o, bit pw);
		longint v;
		v = (longint'(x) - 4000) * 10000 / 16000 + o;
		if (pw && v < 0)
			v = 0;
		if (pw && v > 100000)
			v = 100000;
		return v[31:0];
	endfunction
	initial begin
		repeat (60000) @(posedge clock);
		errors++;
		final_report;
	end
	initial begin
		void'($urandom(32'h0693));
		repeat (6) @(posedge clock);
		reset <= 1'b0;
		rd(`PIS_REG_STATUS);
		check_flag(rv[1], 1'b1);
		rd(`PIS_REG_SCALE_LO);
		check_word(rv, 32'd4000);
		rd(8'hfc);
		check_word(rv, 32'h0);
		wr(`PIS_REG_SCALE_HI, 32'd2000000);
		rd(`PIS_REG_SCALE_HI);
		check_word(rv, 32'd1000000);
		wr(`PIS_REG_SCALE_HI, 32'd20000);
		wr(`PIS_REG_RANGE_LO, -32'sd200000000);
		rd(`PIS_REG_RANGE_LO);
		check_word(rv, `PIS_PROC_MIN);
		wr(`PIS_REG_RANGE_LO, 32'h0);
		// Celsius temperature narrows the process span
		wr(`PIS_REG_CTRL, 32'h10d);
		wr(`PIS_REG_RANGE_HI, 32'd60000000);
		rd(`PIS_REG_RANGE_HI);
		check_word(rv, `PIS_CELS_MAX);
		wr(`PIS_REG_RANGE_HI, 32'd10000);
		// Every unit and precision and each sourced input type, quarter-point example
		for (int i = 0; i < 4; i++) begin
			wr(`PIS_REG_CTRL, i * 20 + 1 + i % 3);
			#1 check_word({30'h0, output_units}, i);
			check_word({30'h0, display_precision}, i);
			put(8000);
			check_flag(not_sourced, 1'b0);
			rd(`PIS_REG_VALUE);
			check_word(rv, expect_val(8000, 0, i == 0));
		end
		// Random levels and offsets in power units; first one clips
		wr(`PIS_REG_CTRL, 32'h3);
		for (int i = 0; i < 6; i++) begin
			lv = (i == 0) ? 20000 : 4000 + $urandom_range(16000);
			off = (i == 0) ? 200000 : $urandom_range(200000) - 100000;
			wr(`PIS_REG_OFFSET, off);
			put(lv);
			rd(`PIS_REG_VALUE);
			check_word(rv, expect_val(lv, off, 1'b1));
		end
		wr(`PIS_REG_OFFSET, 32'h0);
		wr(`PIS_REG_CTRL, 32'h7);
		// Settle at zero unfiltered, then step with slow settings
		put(4000);
		wr(`PIS_REG_FILTER, 32'd9999);
		rd(`PIS_REG_FILTER);
		check_word(rv, 32'd600);
		put(20000);
		rd(`PIS_REG_VALUE);
		check_flag($signed(rv) < 10000, 1'b1);
		wr(`PIS_REG_FILTER, 32'd10);
		put(20000);
		rd(`PIS_REG_VALUE);
		check_flag($signed(rv) < 10000, 1'b1);
		wr(`PIS_REG_FILTER, 32'h0);
		put(20000);
		rd(`PIS_REG_VALUE);
		check_word(rv, expect_val(20000, 0, 1'b0));
		// Low-signal error, unlatched then latched
		wr(`PIS_REG_ERR_LOW, 32'd3000);
		wr(`PIS_REG_CTRL, 32'h47);
		put(1000);
		rd(`PIS_REG_STATUS);
		check_flag(rv[0], 1'b1);
		put(8000);
		rd(`PIS_REG_STATUS);
		check_flag(rv[0], 1'b0);
		wr(`PIS_REG_CTRL, 32'hc7);
		put(1000);
		wr(`PIS_REG_CLEAR, 32'h1);
		put(8000);
		rd(`PIS_REG_STATUS);
		check_flag(rv[0], 1'b1);
		wr(`PIS_REG_CLEAR, 32'h1);
		rd(`PIS_REG_STATUS);
		check_flag(rv[0], 1'b0);
		wr(`PIS_REG_CTRL, 32'h0);
		put(8000);
		check_flag(loop_hold_zero, 1'b1);
		rd(`PIS_REG_VALUE);
		check_word(rv, 32'h0);
		for (int i = 0; i < 5; i++) begin
			nm[i] = $urandom;
			wr(`PIS_REG_NAME0 + 8'(4 * i), nm[i]);
		end
		for (int i = 0; i < 5; i++) begin
			rd(`PIS_REG_NAME0 + 8'(4 * i));
			check_word(rv, nm[i]);
		end
		final_report;
	end
endmodule
`default_nettype wire
